//--- rtl/lpms_pkg.sv
// Package with states, timing constants and carriers for the mode sequencer.
package lpms_pkg;

  // Clock period in picoseconds at 100 MHz.
  localparam int unsigned CLK_PERIOD_PS = 10000;

  // Oscillator settle time and converter soft-start time, in milliseconds.
  localparam int unsigned OSC_SETTLE_MS = 10;
  localparam int unsigned SOFT_START_MS = 20;

  // Cycle counts derived from the times and the clock rate. The division
  // comes first, because milliseconds in picoseconds overflow 32 bits.
  localparam int unsigned OSC_SETTLE_CYC =
    OSC_SETTLE_MS * (1000000000 / CLK_PERIOD_PS);
  localparam int unsigned SOFT_START_CYC =
    SOFT_START_MS * (1000000000 / CLK_PERIOD_PS);

  // Supply-good threshold in millivolts, and width of the supply samples.
  localparam int unsigned SUPPLY_MV_W = 13;
  localparam logic [12:0] SUPPLY_GOOD_MV = 13'h05DC;

  // Timer width wide enough for the longest interval.
  localparam int unsigned TMR_W = 32;

  // Default values of the control bits after any reset.
  localparam logic ACTIVE_REQ_RST = 1'b0;
  localparam logic CONV_EN_RST = 1'b0;

  // Operating modes.
  typedef enum logic [2:0] {
    LPMS_RESET = 3'b000,
    LPMS_STANDBY = 3'b001,
    LPMS_STARTUP = 3'b010,
    LPMS_SOFTSTART = 3'b011,
    LPMS_NORMAL = 3'b100
  } lpms_state_t;

  // Control bits as written by the host.
  typedef struct packed {
    logic active_request_bit;
    logic conv_en;
  } lpms_ctrl_t;

  // Enables driven to the analog and LED blocks.
  typedef struct packed {
    logic core_en;
    logic conv_run;
    logic conv_low_current;
    logic led_en;
  } lpms_enables_t;

endpackage

//--- rtl/lpms_supply_por.sv
// Supply monitor that raises the supply-up reset while a core supply is low.
`timescale 1ns/100ps
`default_nettype none
module lpms_supply_por
  import lpms_pkg::*;
(
  input wire logic clk_sys_i,
  input wire logic rst_n_i,
  input wire logic [SUPPLY_MV_W-1:0] vdd1_mv_i,
  input wire logic [SUPPLY_MV_W-1:0] vdd2_mv_i,
  output logic por_o
);

  logic supply_ok;
  logic por_r;

  // Both supplies must exceed the threshold for the reset to release.
  assign supply_ok = (vdd1_mv_i > SUPPLY_GOOD_MV) &&
    (vdd2_mv_i > SUPPLY_GOOD_MV);

  // Asserted from chip start-up until both supplies are good, and again
  // on any sag to or below threshold.
  always_ff @(posedge clk_sys_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      por_r <= 1'b1;
    end
    else
    begin
      por_r <= !supply_ok;
    end
  end

  // A sag is seen at once so no state runs on a collapsing supply.
  assign por_o = por_r || !supply_ok;

  AST_POR_SAG: assert property (@(posedge clk_sys_i)
    disable iff (!rst_n_i)
    (vdd1_mv_i <= SUPPLY_GOOD_MV || vdd2_mv_i <= SUPPLY_GOOD_MV) |-> por_o)
    else $error("Supply-up reset not raised on low supply.");

endmodule
`default_nettype wire

//--- rtl/lpms_timer.sv
// Down-counting interval timer with a load pulse and a one-cycle done pulse.
`timescale 1ns/100ps
`default_nettype none
module lpms_timer
  import lpms_pkg::*;
#(
  parameter int unsigned W = TMR_W
)
(
  input wire logic clk_sys_i,
  input wire logic rst_n_i,
  input wire logic clr_i,
  input wire logic load_i,
  input wire logic [W-1:0] count_i,
  output logic done_o
);

  logic [W-1:0] cnt_r;
  logic [W-1:0] cnt_nxt;
  logic zero;

  assign zero = (cnt_r == '0);
  assign cnt_nxt = clr_i ? '0 : load_i ? count_i : zero ? cnt_r :
    cnt_r - W'(1);

  // Clear wins over load so a reset never leaves a stale interval.
  always_ff @(posedge clk_sys_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      cnt_r <= '0;
    end
    else
    begin
      cnt_r <= cnt_nxt;
    end
  end

  // Done only at the last count, which comes straight after a load only when the count is 1.
  assign done_o = (cnt_r == W'(1));

endmodule
`default_nettype wire

//--- rtl/lpms_sequencer.sv
// Operating-mode sequencer of the lighting management unit.
`timescale 1ns/100ps
`default_nettype none
module lpms_sequencer
  import lpms_pkg::*;
#(
  parameter int unsigned OSC_CYC = OSC_SETTLE_CYC,
  parameter int unsigned SOFT_CYC = SOFT_START_CYC
)
(
  input wire logic clk_sys_i,
  input wire logic rst_n_i,
  input wire logic external_reset_low_n_i,
  input wire logic [SUPPLY_MV_W-1:0] vdd1_mv_i,
  input wire logic [SUPPLY_MV_W-1:0] vdd2_mv_i,
  input wire logic overheat_shutdown_i,
  input wire logic ctrl_we_i,
  input wire lpms_ctrl_t ctrl_wdata_i,
  output lpms_ctrl_t ctrl_o,
  output lpms_enables_t en_o,
  output lpms_state_t state_o
);

  lpms_state_t state_r;
  lpms_state_t state_nxt;
  lpms_ctrl_t ctrl_r;
  lpms_ctrl_t ctrl_nxt;
  lpms_enables_t en_r;
  lpms_enables_t en_nxt;
  logic por;
  logic any_reset;
  logic osc_done;
  logic soft_done;
  logic osc_load;
  logic soft_load;
  logic enter_startup;
  logic enter_soft;
  logic conv_rise;
  logic tmr_clr;

  // Supply monitor producing the internal supply-up reset.
  lpms_supply_por u_por (
    .clk_sys_i(clk_sys_i),
    .rst_n_i(rst_n_i),
    .vdd1_mv_i(vdd1_mv_i),
    .vdd2_mv_i(vdd2_mv_i),
    .por_o(por)
  );

  // Either reset source overrides every state.
  assign any_reset = !external_reset_low_n_i || por;

  // Control register: defaults in reset, host writes in every other state.
  // Writes in standby are taken; the request bit starts start-up, conv_en is acted on at its end.
  assign ctrl_nxt = (state_r == LPMS_RESET || any_reset) ?
    {ACTIVE_REQ_RST, CONV_EN_RST} :
    ctrl_we_i ? ctrl_wdata_i : ctrl_r;

  always_ff @(posedge clk_sys_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      ctrl_r <= '{ACTIVE_REQ_RST, CONV_EN_RST};
    end
    else
    begin
      ctrl_r <= ctrl_nxt;
    end
  end

  // A host write raising the converter enable; only normal mode acts on it.
  assign conv_rise = ctrl_we_i && ctrl_wdata_i.conv_en && !ctrl_r.conv_en;

  // Transition terms; enter_soft loads the soft-start timer, enter_startup feeds a check.
  assign enter_startup = (state_r == LPMS_STANDBY) &&
    ctrl_r.active_request_bit && !any_reset;
  assign enter_soft = (state_nxt == LPMS_SOFTSTART) &&
    (state_r != LPMS_SOFTSTART);
  // Every entry to start-up loads the timer, so a one-cycle overheat in a
  // later mode cannot leave start-up waiting on an idle timer.
  assign osc_load = (state_nxt == LPMS_STARTUP) &&
    ((state_r != LPMS_STARTUP) || overheat_shutdown_i);
  assign soft_load = enter_soft;
  assign tmr_clr = any_reset || !ctrl_r.active_request_bit;

  // Oscillator settle interval in start-up.
  lpms_timer u_osc_tmr (
    .clk_sys_i(clk_sys_i),
    .rst_n_i(rst_n_i),
    .clr_i(tmr_clr),
    .load_i(osc_load),
    .count_i(TMR_W'(OSC_CYC)),
    .done_o(osc_done)
  );

  // Converter soft-start interval.
  lpms_timer u_soft_tmr (
    .clk_sys_i(clk_sys_i),
    .rst_n_i(rst_n_i),
    .clr_i(tmr_clr),
    .load_i(soft_load),
    .count_i(TMR_W'(SOFT_CYC)),
    .done_o(soft_done)
  );

  // Mode transitions. Reset and a dropped request take precedence.
  always_comb
  begin
    state_nxt = state_r;
    case (state_r)
      LPMS_RESET:
      begin
        if (!any_reset)
        begin
          state_nxt = LPMS_STANDBY;
        end
      end
      LPMS_STANDBY:
      begin
        if (ctrl_r.active_request_bit)
        begin
          state_nxt = LPMS_STARTUP;
        end
      end
      LPMS_STARTUP:
      begin
        // Overheat keeps reloading the timer, so start-up is held.
        if (osc_done && !overheat_shutdown_i)
        begin
          state_nxt = ctrl_r.conv_en ? LPMS_SOFTSTART :
            LPMS_NORMAL;
        end
      end
      LPMS_SOFTSTART:
      begin
        if (soft_done)
        begin
          state_nxt = LPMS_NORMAL;
        end
      end
      LPMS_NORMAL:
      begin
        if (conv_rise)
        begin
          state_nxt = LPMS_SOFTSTART;
        end
      end
      default:
      begin
        state_nxt = LPMS_RESET;
      end
    endcase
    if (overheat_shutdown_i && state_r != LPMS_RESET &&
      state_r != LPMS_STANDBY)
    begin
      state_nxt = LPMS_STARTUP;
    end
    if (!ctrl_r.active_request_bit && state_r != LPMS_RESET)
    begin
      state_nxt = LPMS_STANDBY;
    end
    if (any_reset)
    begin
      state_nxt = LPMS_RESET;
    end
  end

  always_ff @(posedge clk_sys_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      state_r <= LPMS_RESET;
    end
    else
    begin
      state_r <= state_nxt;
    end
  end

  // Enables follow the next state so they change with the mode itself.
  always_comb
  begin
    en_nxt = '0;
    case (state_nxt)
      LPMS_STARTUP:
      begin
        // Overheat disables chip operation including the core blocks.
        en_nxt.core_en = !overheat_shutdown_i;
      end
      LPMS_SOFTSTART:
      begin
        en_nxt.core_en = 1'b1;
        en_nxt.conv_run = 1'b1;
        en_nxt.conv_low_current = 1'b1;
        en_nxt.led_en = 1'b0;
      end
      LPMS_NORMAL:
      begin
        en_nxt.core_en = 1'b1;
        // Converter sits in its own standby while its enable is low.
        en_nxt.conv_run = ctrl_nxt.conv_en;
        en_nxt.led_en = 1'b1;
      end
      default:
      begin
        en_nxt = '0;
      end
    endcase
  end

  always_ff @(posedge clk_sys_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      en_r <= '0;
    end
    else
    begin
      en_r <= en_nxt;
    end
  end

  assign ctrl_o = ctrl_r;
  assign en_o = en_r;
  assign state_o = state_r;

  // Cycle counters for the interval checks. The start-up count restarts
  // while overheat is high, as the settle timer itself does.
  logic [TMR_W-1:0] soft_age_r;
  logic [TMR_W-1:0] osc_age_r;
  always_ff @(posedge clk_sys_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      soft_age_r <= '0;
      osc_age_r <= '0;
    end
    else
    begin
      soft_age_r <= (state_r == LPMS_SOFTSTART) ?
        soft_age_r + TMR_W'(1) : '0;
      osc_age_r <= (state_r == LPMS_STARTUP && !overheat_shutdown_i) ?
        osc_age_r + TMR_W'(1) : '0;
    end
  end

  AST_RESET_ENTRY: assert property (@(posedge clk_sys_i)
    disable iff (!rst_n_i)
    any_reset |=> state_r == LPMS_RESET)
    else $error("A reset source did not force the reset state.");

  AST_RESET_DEFAULTS: assert property (@(posedge clk_sys_i)
    disable iff (!rst_n_i)
    state_r == LPMS_RESET |=> !ctrl_r.active_request_bit &&
    !ctrl_r.conv_en)
    else $error("Control bits not at defaults after reset state.");

  AST_STANDBY_DARK: assert property (@(posedge clk_sys_i)
    disable iff (!rst_n_i)
    state_r == LPMS_STANDBY |-> en_r == '0)
    else $error("Circuitry enabled in standby.");

  AST_STANDBY_ENTRY: assert property (@(posedge clk_sys_i)
    disable iff (!rst_n_i)
    !ctrl_r.active_request_bit && !any_reset && state_r != LPMS_RESET
    |=> state_r == LPMS_STANDBY)
    else $error("Standby not entered with request low.");

  AST_STARTUP_BEGIN: assert property (@(posedge clk_sys_i)
    disable iff (!rst_n_i)
    enter_startup && !overheat_shutdown_i |=> state_r == LPMS_STARTUP &&
    en_r.core_en)
    else $error("Start-up did not begin on active request.");

  // Resets and a dropped request may cut start-up short; only the way on
  // to soft-start or normal has to wait the full settle interval.
  AST_OSC_WAIT: assert property (@(posedge clk_sys_i)
    disable iff (!rst_n_i)
    state_r == LPMS_STARTUP && state_nxt inside {LPMS_SOFTSTART,
    LPMS_NORMAL} |-> osc_age_r == TMR_W'(OSC_CYC - 1))
    else $error("Start-up left before the settle interval.");

  AST_OVERHEAT_HOLD: assert property (@(posedge clk_sys_i)
    disable iff (!rst_n_i)
    overheat_shutdown_i && state_r inside {LPMS_STARTUP, LPMS_NORMAL,
    LPMS_SOFTSTART} && ctrl_r.active_request_bit && !any_reset
    |=> state_r == LPMS_STARTUP && !en_r.core_en)
    else $error("Overheat did not hold start-up.");

  AST_SOFT_LEDS_OFF: assert property (@(posedge clk_sys_i)
    disable iff (!rst_n_i)
    state_r == LPMS_SOFTSTART |-> !en_r.led_en && en_r.conv_low_current)
    else $error("LEDs on or converter not low-current in soft-start.");

  AST_SOFT_LENGTH: assert property (@(posedge clk_sys_i)
    disable iff (!rst_n_i)
    state_r == LPMS_SOFTSTART && state_nxt == LPMS_NORMAL
    |-> soft_age_r == TMR_W'(SOFT_CYC - 1))
    else $error("Soft-start did not run its interval.");

  AST_CONV_STANDBY: assert property (@(posedge clk_sys_i)
    disable iff (!rst_n_i)
    state_r == LPMS_NORMAL && !ctrl_r.conv_en |-> !en_r.conv_run)
    else $error("Converter running with enable low in normal mode.");

endmodule
`default_nettype wire

//--- test/lpms_host_model.sv
// Behavioural host that writes the control bits of the mode sequencer.
`timescale 1ns/100ps
`default_nettype none
module lpms_host_model
  import lpms_pkg::*;
(
  input wire logic clk_sys_i,
  output var logic ctrl_we_o,
  output var lpms_ctrl_t ctrl_wdata_o
);
  // Converter voltage code that the host keeps; 8'h08 is the lowest step.
  logic [7:0] vout_code_r = 8'h14;

  // Idle bus at time zero.
  initial
  begin
    ctrl_we_o = 1'h0;
    ctrl_wdata_o = lpms_ctrl_t'(2'h2);
  end

  // One write holds strobe and data for a full cycle between falling edges.
  // At the end of a write the data lines flip, so a stale word can never pass as valid.
  task automatic write_ctrl(input logic act, input logic conv);
    @(negedge clk_sys_i);
    if (!act)
      vout_code_r = 8'h08;
    ctrl_wdata_o = lpms_ctrl_t'({act, conv});
    ctrl_we_o = 1'h1;
    @(negedge clk_sys_i);
    ctrl_we_o = 1'h0;
    ctrl_wdata_o = lpms_ctrl_t'(~ctrl_wdata_o);
  endtask
endmodule
`default_nettype wire

//--- test/lpms_sequencer_test.sv
// Self-checking bench for the operating-mode sequencer.
`timescale 1ns/100ps
`default_nettype none
`define CHK(got, exp, msg) \
  begin \
    num_checks++; \
    if ((got) !== (exp)) \
    begin \
      err_count++; \
      $display("BAD %0t %s", $time, msg); \
    end \
  end
module lpms_sequencer_test
  import lpms_pkg::*;
();
  // Short intervals keep the run brief; expectations derive from these.
  localparam int OSC = 20;
  localparam int SOFT = 40;
  logic clk = 1'h0;
  logic rst_n = 1'h0;
  logic ext_rst_n = 1'h1;
  logic overheat = 1'h0;
  logic [SUPPLY_MV_W-1:0] vdd1 = 13'h0BB8;
  logic [SUPPLY_MV_W-1:0] vdd2 = 13'h0BB8;
  logic we;
  lpms_ctrl_t wdata;
  lpms_ctrl_t ctrl;
  lpms_enables_t en;
  lpms_state_t state;
  int err_count = 0;
  int num_checks = 0;
  int n;
  int led_on;

  lpms_sequencer #(.OSC_CYC(OSC), .SOFT_CYC(SOFT)) lpms_sequencer_i (
    .clk_sys_i(clk),
    .rst_n_i(rst_n),
    .external_reset_low_n_i(ext_rst_n),
    .vdd1_mv_i(vdd1),
    .vdd2_mv_i(vdd2),
    .overheat_shutdown_i(overheat),
    .ctrl_we_i(we),
    .ctrl_wdata_i(wdata),
    .ctrl_o(ctrl),
    .en_o(en),
    .state_o(state)
  );

  lpms_host_model lpms_host_model_i (
    .clk_sys_i(clk),
    .ctrl_we_o(we),
    .ctrl_wdata_o(wdata)
  );

  // Free-running 100 MHz clock.
  initial
  begin
    forever #5 clk = ~clk;
  end

  // Bounded wait for a mode; n counts cycles, led_on counts lit cycles.
  task automatic wait_state(input lpms_state_t s, input int max);
    n = 0;
    led_on = 0;
    while (state !== s && n < max)
    begin
      if (en.led_en !== 1'h0)
        led_on++;
      @(negedge clk);
      n++;
    end
    `CHK(state, s, "mode not reached")
  endtask

  task automatic t_power_up();
    wait_state(LPMS_STANDBY, 10);
    `CHK(ctrl, lpms_ctrl_t'(2'h0), "ctrl not default")
    `CHK(en, lpms_enables_t'(4'h0), "standby enables")
  endtask

  task automatic t_full_boot();
    lpms_host_model_i.write_ctrl(1'h1, 1'h1);
    `CHK(ctrl, lpms_ctrl_t'(2'h3), "write not taken")
    `CHK(state, LPMS_STANDBY, "left standby early")
    wait_state(LPMS_STARTUP, 3);
    `CHK(en, lpms_enables_t'(4'h8), "startup enables")
    wait_state(LPMS_SOFTSTART, OSC + 3);
    `CHK(n, OSC, "settle length")
    `CHK(en, lpms_enables_t'(4'hE), "soft-start enables")
    wait_state(LPMS_NORMAL, SOFT + 3);
    `CHK(n, SOFT, "soft-start length")
    `CHK(led_on, 0, "led lit in soft-start")
    `CHK(en, lpms_enables_t'(4'hD), "normal enables")
  endtask

  task automatic t_boost_toggle();
    lpms_host_model_i.write_ctrl(1'h1, 1'h0);
    repeat (2) @(negedge clk);
    `CHK(state, LPMS_NORMAL, "normal lost")
    `CHK(en.conv_run, 1'h0, "converter still on")
    lpms_host_model_i.write_ctrl(1'h1, 1'h1);
    wait_state(LPMS_SOFTSTART, 3);
    `CHK(en.led_en, 1'h0, "led in soft-start")
    wait_state(LPMS_NORMAL, SOFT + 3);
    `CHK(n, SOFT, "re-entered soft-start length")
  endtask

  task automatic t_overheat();
    overheat = 1'h1;
    wait_state(LPMS_STARTUP, 3);
    `CHK(en.core_en, 1'h0, "core left on")
    repeat (OSC + 5) @(negedge clk);
    `CHK(state, LPMS_STARTUP, "left startup while hot")
    overheat = 1'h0;
    wait_state(LPMS_SOFTSTART, OSC + 3);
    `CHK(n >= OSC - 1 && n <= OSC + 1, 1'h1, "settle after heat")
    wait_state(LPMS_NORMAL, SOFT + 3);
    // A single-cycle overheat must still restart the full settle interval.
    overheat = 1'h1;
    @(negedge clk);
    overheat = 1'h0;
    `CHK(state, LPMS_STARTUP, "overheat pulse ignored")
    wait_state(LPMS_SOFTSTART, OSC + 3);
    `CHK(n, OSC, "settle after pulse")
    wait_state(LPMS_NORMAL, SOFT + 3);
  endtask

  task automatic t_standby_return();
    lpms_host_model_i.write_ctrl(1'h0, 1'h1);
    wait_state(LPMS_STANDBY, 3);
    `CHK(en, lpms_enables_t'(4'h0), "enables after standby")
    `CHK(lpms_host_model_i.vout_code_r, 8'h08, "code not lowest")
    lpms_host_model_i.write_ctrl(1'h1, 1'h0);
    wait_state(LPMS_STARTUP, 3);
    wait_state(LPMS_NORMAL, OSC + 3);
    `CHK(n, OSC, "startup to normal")
  endtask

  task automatic t_resets();
    ext_rst_n = 1'h0;
    wait_state(LPMS_RESET, 3);
    `CHK(ctrl, lpms_ctrl_t'(2'h0), "ctrl kept in reset")
    lpms_host_model_i.write_ctrl(1'h1, 1'h1);
    `CHK(ctrl, lpms_ctrl_t'(2'h0), "write taken in reset")
    ext_rst_n = 1'h1;
    wait_state(LPMS_STANDBY, 4);
    lpms_host_model_i.write_ctrl(1'h1, 1'h0);
    wait_state(LPMS_STARTUP, 3);
    vdd2 = 13'h05DC;
    wait_state(LPMS_RESET, 3);
    `CHK(ctrl.active_request_bit, 1'h0, "active bit kept")
    repeat (4) @(negedge clk);
    `CHK(state, LPMS_RESET, "reset left at threshold")
    vdd2 = 13'h05DD;
    wait_state(LPMS_STANDBY, 4);
  endtask

  // Prints the verdict and ends the run.
  task automatic complete_run();
    if (err_count == 0 && num_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  // Main sequence; reset is released on a falling edge after six cycles.
  initial
  begin
    repeat (6) @(negedge clk);
    rst_n = 1'h1;
    t_power_up();
    t_full_boot();
    t_boost_toggle();
    t_overheat();
    t_standby_return();
    t_resets();
    complete_run();
  end

  // Watchdog well beyond the few hundred cycles the scenarios need.
  initial
  begin
    #100000;
    err_count++;
    complete_run();
  end
endmodule
`undef CHK
`default_nettype wire
